// [hw/satcap_params.svh]
// Word indices, bit positions, command codes and reset values of the capability words
`ifndef SATCAP_PARAMS_SVH
`define SATCAP_PARAMS_SVH

`define SATCAP_IDX_CAP 8'h4c
`define SATCAP_IDX_RSVD 8'h4d
`define SATCAP_IDX_SUP 8'h4e
`define SATCAP_IDX_EN 8'h4f

`define SATCAP_BIT_GEN1 1
`define SATCAP_BIT_GEN2 2
`define SATCAP_BIT_HOST_PM 9
`define SATCAP_BIT_PHY_CNT 10
`define SATCAP_FEAT_LSB 1
`define SATCAP_FEAT_MSB 6

`define SATCAP_PRESERVE_IDX 3'h5

`define SATCAP_SF_ENABLE 8'h10
`define SATCAP_SF_DISABLE 8'h90
`define SATCAP_SF_FIRST 8'h01
`define SATCAP_SF_LAST 8'h06

`define SATCAP_WORD_ZERO 16'h0000
`define SATCAP_WORD_ONES 16'hffff
`define SATCAP_EN_RESET 6'h00
`define SATCAP_FEAT_RESET 6'h00

`endif

// [hw/satcap_pkg.sv]
// Types shared by the capability word logic
package satcap_pkg;

  typedef struct packed {
    logic phy_counters;
    logic host_pm;
    logic gen2;
    logic gen1;
    logic [5:0] feat;
  } satcap_caps_t;

  typedef struct packed {
    logic [15:0] cap;
    logic [15:0] rsvd;
    logic [15:0] sup;
    logic [15:0] en;
  } satcap_words_t;

  typedef struct packed {
    logic valid;
    logic [7:0] feature;
    logic [7:0] count;
  } satcap_sf_req_t;

  typedef enum logic [1:0] {
    SATCAP_IDLE = 2'b01,
    SATCAP_REPLY = 2'b10
  } satcap_state_t;

endpackage : satcap_pkg

// [hw/satcap_word_port.sv]
// Registered read port for identify words 76 to 79
`include "satcap_params.svh"

module satcap_word_port (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Read request
  input wire logic rd_en,
  input wire logic [7:0] rd_index,
  input wire satcap_pkg::satcap_words_t words,
  // Registered answer
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_hit
);

  logic [15:0] next_rd_data;
  logic next_rd_valid;
  logic next_rd_hit;

  always_comb begin
    next_rd_valid = rd_en;
    next_rd_hit = 1'b0;
    next_rd_data = `SATCAP_WORD_ZERO;
    if (rd_en) begin
      next_rd_hit = 1'b1;
      case (rd_index)
        `SATCAP_IDX_CAP: next_rd_data = words.cap;
        `SATCAP_IDX_RSVD: next_rd_data = words.rsvd;
        `SATCAP_IDX_SUP: next_rd_data = words.sup;
        `SATCAP_IDX_EN: next_rd_data = words.en;
        // Other identify words belong to the surrounding identify logic
        default: next_rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= `SATCAP_WORD_ZERO;
      rd_valid <= 1'b0;
      rd_hit <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= next_rd_valid;
      rd_hit <= next_rd_hit;
    end
  end

endmodule : satcap_word_port

// [hw/satcap_identify_words.sv]
// Serial ATA capability, supported and enabled identify words with feature control
// Notes on behaviour
// - Word 76 neither all zeros nor ones claims compliance; 77-79 then valid
// - Word 76 bit 0 always zero
// - Word 76 bit 1 for Gen-1, bit 2 for Gen-2; both allowed
// - Word 76 bits 3 to 8 read zero for a packet device
// - Word 76 bit 9 set only with host-initiated Partial/Slumber support
// - Word 76 bit 10 advertises phy event counters and log page 11h
// - Word 76 bits 11 to 15 read zero
// - Word 77 always reads zero
// - Word 78 zero when unimplemented; bit 0 always zero
// - Word 78 bit 1 only with non-zero buffer offset support
// - Word 78 bit 2 only with auto-activate support
// - Word 78 bit 3 only with device-initiated power management
// - Word 78 bit 4 means in-order delivery; defaults to zero
// - Word 78 bit 5 only with asynchronous notification support
// - Word 78 bit 6 means settings survive link reset
// - Word 78 bits 7 to 15 read zero
// - Word 79 bits 1-6 give enabled state; others read zero
// - Supported words fixed; change only on media change
// - Enabled flags default zero; preservation defaults to its support
// - Set features 10h enables, 90h disables, count 01h-06h selects
`include "satcap_params.svh"

module satcap_identify_words (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Device capability straps and media events
  input wire satcap_pkg::satcap_caps_t caps_in,
  input wire logic media_change,
  input wire logic comreset,
  // Set features command
  input wire satcap_pkg::satcap_sf_req_t sf_req,
  output logic sf_done,
  output logic sf_error,
  // Identify word read
  input wire logic id_rd,
  input wire logic [7:0] id_index,
  output logic [15:0] id_data,
  output logic id_valid,
  output logic id_hit,
  // Enabled feature flags for the transport logic, bits 1 to 6
  output logic [5:0] feat_enabled
);

  function automatic logic [15:0] build_cap(input satcap_pkg::satcap_caps_t c);
    logic [15:0] w;
    w = `SATCAP_WORD_ZERO;
    w[`SATCAP_BIT_GEN1] = c.gen1;
    w[`SATCAP_BIT_GEN2] = c.gen2;
    w[`SATCAP_BIT_HOST_PM] = c.host_pm;
    w[`SATCAP_BIT_PHY_CNT] = c.phy_counters;
    return w;
  endfunction : build_cap

  function automatic logic [15:0] build_flags(input logic [5:0] f);
    logic [15:0] w;
    w = `SATCAP_WORD_ZERO;
    w[`SATCAP_FEAT_MSB:`SATCAP_FEAT_LSB] = f;
    return w;
  endfunction : build_flags

  function automatic logic [5:0] default_en(input logic [5:0] sup);
    logic [5:0] e;
    e = `SATCAP_EN_RESET;
    e[`SATCAP_PRESERVE_IDX] = sup[`SATCAP_PRESERVE_IDX];
    return e;
  endfunction : default_en

  function automatic logic sf_legal(input satcap_pkg::satcap_sf_req_t r, input logic [5:0] sup);
    logic [2:0] i;
    i = 3'(r.count - `SATCAP_SF_FIRST);
    return ((r.feature == `SATCAP_SF_ENABLE) || (r.feature == `SATCAP_SF_DISABLE)) &&
           (r.count >= `SATCAP_SF_FIRST) && (r.count <= `SATCAP_SF_LAST) && sup[i];
  endfunction : sf_legal

  // Capability straps, caught on the first clock after reset and on media change
  satcap_pkg::satcap_caps_t caps;
  satcap_pkg::satcap_caps_t next_caps;
  logic loaded;
  logic next_loaded;

  always_comb begin
    next_caps = caps;
    next_loaded = 1'b1;
    if (!loaded || media_change) begin
      next_caps = caps_in;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      caps <= '0;
      loaded <= 1'b0;
    end else begin
      caps <= next_caps;
      loaded <= next_loaded;
    end
  end

  // Enabled flags and set features handling
  satcap_pkg::satcap_state_t state;
  satcap_pkg::satcap_state_t next_state;
  logic [5:0] en;
  logic [5:0] next_en;
  logic next_sf_done;
  logic next_sf_error;
  logic [2:0] sf_idx;

  assign sf_idx = 3'(sf_req.count - `SATCAP_SF_FIRST);

  always_comb begin
    next_state = state;
    next_sf_done = 1'b0;
    next_sf_error = 1'b0;
    // Masking by the next supported set drops a flag whose support vanished with the media
    next_en = en;
    case (state)
      satcap_pkg::SATCAP_IDLE: begin
        if (sf_req.valid) begin
          next_state = satcap_pkg::SATCAP_REPLY;
          next_sf_done = 1'b1;
          if (sf_legal(sf_req, caps.feat)) begin
            next_en[sf_idx] = (sf_req.feature == `SATCAP_SF_ENABLE);
          end else begin
            // Unknown codes and unsupported features are aborted, never stored
            next_sf_error = 1'b1;
          end
        end
      end
      satcap_pkg::SATCAP_REPLY: next_state = satcap_pkg::SATCAP_IDLE;
      default: next_state = satcap_pkg::SATCAP_IDLE;
    endcase
    // Link reset returns every flag to its default even with preservation on,
    // since only the settings the flags guard are preserved, not the flags
    if (comreset || !loaded) begin
      next_en = default_en(next_caps.feat);
    end
    next_en = next_en & next_caps.feat;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= satcap_pkg::SATCAP_IDLE;
      en <= `SATCAP_EN_RESET;
      sf_done <= 1'b0;
      sf_error <= 1'b0;
    end else begin
      state <= next_state;
      en <= next_en;
      sf_done <= next_sf_done;
      sf_error <= next_sf_error;
    end
  end

  assign feat_enabled = en;

  // Word images and their read port
  satcap_pkg::satcap_words_t words;

  always_comb begin
    words.cap = build_cap(caps);
    words.rsvd = `SATCAP_WORD_ZERO;
    words.sup = build_flags(caps.feat);
    words.en = build_flags(en);
  end

  satcap_word_port u_port (
    .mclk(mclk),
    .rstn(rstn),
    .rd_en(id_rd),
    .rd_index(id_index),
    .words(words),
    .rd_data(id_data),
    .rd_valid(id_valid),
    .rd_hit(id_hit)
  );

  // Checks
  a_cap_bit0_zero: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_CAP |=> id_valid && id_hit && !id_data[0])
    else $error("word 76 bit 0 set");

  a_cap_resv_zero: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_CAP |=> id_data[8:3] == 6'h00 && id_data[15:11] == 5'h00)
    else $error("word 76 reserved bits set");

  a_cap_not_ones: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_CAP |=> id_data != `SATCAP_WORD_ONES &&
      id_data[2:1] == {$past(caps.gen2), $past(caps.gen1)})
    else $error("word 76 content wrong");

  a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_RSVD |=> id_valid && id_data == `SATCAP_WORD_ZERO)
    else $error("word 77 not zero");

  a_sup_layout: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_SUP |=>
      id_data == {9'h000, $past(caps.feat), 1'b0})
    else $error("word 78 content wrong");

  a_en_within_sup: assert property (@(posedge mclk) disable iff (!rstn)
    (feat_enabled & ~caps.feat) == 6'h00)
    else $error("enabled flag without support");

  a_comreset_dflt: assert property (@(posedge mclk) disable iff (!rstn)
    comreset && !media_change |=> feat_enabled == default_en($past(caps.feat)))
    else $error("flags not at default after link reset");

  a_sf_enable: assert property (@(posedge mclk) disable iff (!rstn)
    state == satcap_pkg::SATCAP_IDLE && sf_req.valid && !comreset && !media_change &&
      sf_legal(sf_req, caps.feat) |=> sf_done && !sf_error &&
      en[$past(sf_idx)] == ($past(sf_req.feature) == `SATCAP_SF_ENABLE) ##1 !sf_done)
    else $error("set features not applied");

  a_sf_reject: assert property (@(posedge mclk) disable iff (!rstn)
    state == satcap_pkg::SATCAP_IDLE && sf_req.valid && !sf_legal(sf_req, caps.feat) &&
      !comreset && !media_change |=> sf_done && sf_error && $stable(en))
    else $error("bad set features not rejected");

  a_caps_fixed: assert property (@(posedge mclk) disable iff (!rstn)
    loaded && !media_change |=> $stable(caps))
    else $error("capabilities changed without media change");

  a_en_layout: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_EN |=>
      id_valid && id_hit && id_data == {9'h000, $past(en), 1'b0})
    else $error("word 79 content wrong");

  a_sup_hit: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_SUP |=> id_valid && id_hit && !id_data[0])
    else $error("word 78 bit 0 set");

  a_cap_gen_bits: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_CAP |=>
      id_data[`SATCAP_BIT_GEN1] == $past(caps.gen1) &&
      id_data[`SATCAP_BIT_GEN2] == $past(caps.gen2))
    else $error("word 76 signaling bits wrong");

  a_cap_pm_bit: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_CAP |=>
      id_data[`SATCAP_BIT_HOST_PM] == $past(caps.host_pm))
    else $error("word 76 bit 9 wrong");

  a_cap_phy_bit: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_CAP |=>
      id_data[`SATCAP_BIT_PHY_CNT] == $past(caps.phy_counters))
    else $error("word 76 bit 10 wrong");

  a_cap_top_zero: assert property (@(posedge mclk) disable iff (!rstn)
    id_rd && id_index == `SATCAP_IDX_CAP |=> id_data[15:11] == 5'h00)
    else $error("word 76 bits 11 to 15 set");

  a_load_default: assert property (@(posedge mclk) disable iff (!rstn)
    !loaded |=> feat_enabled == default_en($past(caps_in.feat)))
    else $error("flags not at default after reset");

  a_pres_default: assert property (@(posedge mclk) disable iff (!rstn)
    comreset && loaded && !media_change |=>
      feat_enabled[`SATCAP_PRESERVE_IDX] == $past(caps.feat[`SATCAP_PRESERVE_IDX]))
    else $error("preservation flag not at default");

  a_order_default: assert property (@(posedge mclk) disable iff (!rstn)
    comreset || !loaded |=> !feat_enabled[3])
    else $error("in-order delivery enabled by default");

  a_media_capture: assert property (@(posedge mclk) disable iff (!rstn)
    media_change |=> caps == $past(caps_in))
    else $error("straps not taken on media change");

  a_media_mask: assert property (@(posedge mclk) disable iff (!rstn)
    media_change && loaded && !comreset && !sf_req.valid |=>
      feat_enabled == ($past(en) & $past(caps_in.feat)))
    else $error("flags not masked to new support");

  a_reply_refuse: assert property (@(posedge mclk) disable iff (!rstn)
    state == satcap_pkg::SATCAP_REPLY |=> !sf_done && !sf_error)
    else $error("command answered in reply state");

  a_reply_hold: assert property (@(posedge mclk) disable iff (!rstn)
    state == satcap_pkg::SATCAP_REPLY && !comreset && !media_change |=> $stable(en))
    else $error("flags moved in reply state");

  a_error_done: assert property (@(posedge mclk) disable iff (!rstn)
    sf_error |-> sf_done)
    else $error("abort without done");

  a_done_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    sf_done |=> !sf_done)
    else $error("done wider than one cycle");

  a_state_onehot: assert property (@(posedge mclk) disable iff (!rstn)
    $onehot(state))
    else $error("command state not one-hot");

  a_words_valid: assert property (@(posedge mclk) disable iff (!rstn)
    caps.gen1 || caps.gen2 |-> words.cap != `SATCAP_WORD_ZERO && words.cap != `SATCAP_WORD_ONES)
    else $error("word 76 not compliant");

endmodule : satcap_identify_words

// [testbench/satcap_host_model.sv]
// Host side model that judges whether the capability words may be trusted
`include "satcap_params.svh"

module satcap_host_model (
  // Clock
  input wire logic mclk,
  // Identify read traffic
  input wire logic id_rd,
  input wire logic [7:0] id_index,
  input wire logic id_valid,
  input wire logic [15:0] id_data,
  // Verdict on words 76 to 79
  output logic words_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_idx = 8'h00;
  logic ok_q = 1'b0;
  assign words_ok = ok_q;
  // Reads are spaced, so one remembered index is enough
  always @(posedge mclk) begin
    if (id_rd) begin
      last_idx <= id_index;
    end
    if (id_valid && last_idx == `SATCAP_IDX_CAP) begin
      ok_q <= id_data !== `SATCAP_WORD_ZERO && id_data !== `SATCAP_WORD_ONES;
    end
  end
endmodule : satcap_host_model

// [testbench/satcap_identify_words_tb.sv]
// Self-checking bench for the capability words and feature control
module satcap_identify_words_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] SUP = 6'h2b;
  logic mclk, rstn, media_change, comreset, id_rd, sf_done, sf_error;
  logic id_valid, id_hit, words_ok;
  logic [7:0] id_index;
  logic [15:0] id_data;
  logic [5:0] feat_enabled;
  logic [5:0] en;
  satcap_pkg::satcap_caps_t caps;
  satcap_pkg::satcap_sf_req_t sf;
  int bad_count = 0;
  int checks_done = 0;

  satcap_identify_words dut_u (
    .mclk(mclk), .rstn(rstn), .caps_in(caps), .media_change(media_change),
    .comreset(comreset), .sf_req(sf), .sf_done(sf_done), .sf_error(sf_error),
    .id_rd(id_rd), .id_index(id_index), .id_data(id_data), .id_valid(id_valid),
    .id_hit(id_hit), .feat_enabled(feat_enabled));
  satcap_host_model host_u (.mclk(mclk), .id_rd(id_rd), .id_index(id_index),
    .id_valid(id_valid), .id_data(id_data), .words_ok(words_ok));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
    @(posedge mclk);
    id_rd <= 1'b1;
    id_index <= idx;
    @(posedge mclk);
    id_rd <= 1'b0;
    #1;
    chk({14'h0, id_valid, id_hit}, {14'h0, 1'b1, idx[7:2] == 6'h13});
    chk(id_data, exp);
  endtask : rd

  task automatic setf(input logic [7:0] f, input logic [7:0] n, input logic err);
    @(posedge mclk);
    sf <= '{1'b1, f, n};
    @(posedge mclk);
    sf.valid <= 1'b0;
    #1;
    chk({14'h0, sf_done, sf_error}, {14'h0, 1'b1, err});
    chk({10'h0, feat_enabled}, {10'h0, en});
  endtask : setf

  // Media change or link reset, one cycle wide
  task automatic pulse(input bit media);
    @(posedge mclk);
    media_change <= media;
    comreset <= !media;
    @(posedge mclk);
    media_change <= 1'b0;
    comreset <= 1'b0;
  endtask : pulse

  task automatic summarize();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : summarize

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial begin
    #(3000 * 50);
    bad_count++;
    summarize();
  end

  initial begin
    logic ok;
    rstn = 1'b0;
    media_change = 1'b0;
    comreset = 1'b0;
    id_rd = 1'b0;
    id_index = 8'h00;
    sf = '{1'b0, 8'h00, 8'h00};
    caps = '{1'b1, 1'b1, 1'b1, 1'b1, SUP};
    en = 6'h20;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(8'h4c, 16'h0606);
    rd(8'h4d, 16'h0000);
    rd(8'h4e, 16'h0056);
    rd(8'h4f, 16'h0040);
    rd(8'h4b, 16'h0000);
    chk({15'h0, words_ok}, 16'h0001);
    // Enable every feature, then disable every one; unsupported ones must abort
    for (int op = 0; op < 2; op++) begin
      for (int n = 1; n <= 6; n++) begin
        ok = SUP[n-1];
        if (ok) begin
          en[n-1] = (op == 0);
        end
        setf(op == 0 ? 8'h10 : 8'h90, 8'(n), !ok);
        rd(8'h4f, {9'h0, en, 1'b0});
      end
    end
    setf(8'h55, 8'h01, 1'b1);
    setf(8'h10, 8'h00, 1'b1);
    setf(8'h10, 8'h07, 1'b1);
    en = 6'h01;
    setf(8'h10, 8'h01, 1'b0);
    // A request held past its answer meets the reply state and is ignored
    @(posedge mclk);
    sf <= '{1'b1, 8'h90, 8'h01};
    @(posedge mclk);
    sf <= '{1'b1, 8'h10, 8'h02};
    #1;
    chk({14'h0, sf_done, sf_error}, 16'h0002);
    @(posedge mclk);
    sf.valid <= 1'b0;
    en = 6'h00;
    #1;
    chk({14'h0, sf_done, sf_error}, 16'h0000);
    chk({10'h0, feat_enabled}, {10'h0, en});
    pulse(1'b0);
    en = 6'h20;
    rd(8'h4f, 16'h0040);
    chk({10'h0, feat_enabled}, {10'h0, en});
    // Straps move without a media change: words must not follow
    @(posedge mclk);
    caps <= '{1'b0, 1'b0, 1'b0, 1'b1, 6'h21};
    rd(8'h4c, 16'h0606);
    rd(8'h4e, 16'h0056);
    pulse(1'b1);
    rd(8'h4c, 16'h0002);
    rd(8'h4e, 16'h0042);
    rd(8'h4f, 16'h0040);
    @(posedge mclk);
    caps <= '{1'b0, 1'b0, 1'b0, 1'b0, 6'h00};
    pulse(1'b1);
    rd(8'h4c, 16'h0000);
    // The host judges the word at the edge after the answer appears
    @(posedge mclk);
    #1;
    chk({15'h0, words_ok}, 16'h0000);
    rd(8'h4f, 16'h0000);
    summarize();
  end
endmodule : satcap_identify_words_tb
